// File: fbcr_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "fbcr_defines.vh"
// register map, byte addressed, 32-bit words only:
//   compression control second: plane select, fence enable, idle mode, double buffer
//   bit 31 of its read value mirrors the compressing input
//   display y offset: 12-bit field, upper bits read zero
//   modification threshold: bit 0 valid, bits 31:1 the count
//   line pair tag table: 49 words from the table base, 4 bytes apart
// tag table layout:
//   each word holds 16 two-bit tags, one per line pair, so 32 lines a word
//   48 words cover 1536 lines; the last word takes the spill of an odd start
//   lines beyond the table read as modified so that nothing past it is trusted
// hazards:
//   a host write to a tag word beats a compressor update of that word
//   plane select must only change while no pass is running; not checked here
//   mode 11 is reserved and behaves like mode 00
module fbcr_regs (
  input wire mclk,
  input wire nrst,
  // host register port
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  // compressor side
  input wire compressing,
  input wire pair_done,
  input wire c3_entry_signal,
  input wire odd_tile_start,
  input wire buf_write,
  input wire cpu_fence_write,
  input wire interval_end,
  input wire tag_wr,
  input wire [10:0] tag_line,
  input wire [1:0] tag_code,
  output wire [1:0] tag_rd_code,
  output wire pair_eligible,
  output wire pair_skip,
  output wire pair_compressed,
  output wire pair_modified,
  output wire plane_b_select,
  output wire cpu_fence_enable,
  output wire dbuf_disable,
  output wire [11:0] fence_display_y_offset,
  output wire compressor_idle,
  output wire idle_gates_sr,
  output wire recompress_ok,
  output wire sr_exit_allow
);
  reg [31:0] ctrl2_reg;
  reg [11:0] yoff_reg;
  reg [31:0] modth_reg;
  reg [31:0] tag_reg [0:`FBCR_TAG_WORDS-1];
  reg idle_reg;
  reg idle_next;
  reg [31:0] rdata_next;
  wire [1:0] idle_mode;
  wire mod_valid;
  wire [30:0] mod_count;
  wire mod_reached;
  wire mod_event;
  wire [11:0] tag_bit;
  wire [5:0] tag_idx;
  wire [3:0] tag_pos;
  wire tag_in_range;
  wire ctrl2_wr;
  wire yoff_wr;
  wire modth_wr;
  wire host_tag_wr;
  wire upd_tag_wr;
  wire [5:0] host_idx;
  wire host_tag_hit;
  wire [1:0] cur_tag;
  integer i;

  // word index of a host address inside the tag table
  function [5:0] tag_index;
    input [15:0] addr;
    reg [15:0] diff;
    begin
      diff = addr - `FBCR_TAG_BASE;
      tag_index = diff[7:2];
    end
  endfunction

  // true when an address falls on a tag word
  function tag_hit;
    input [15:0] addr;
    reg [15:0] diff;
    begin
      diff = addr - `FBCR_TAG_BASE;
      tag_hit = (addr >= `FBCR_TAG_BASE) && (diff[1:0] == 2'h0) &&
                (diff[15:2] < 14'h0031);
    end
  endfunction

  // field views of the control registers
  assign idle_mode = ctrl2_reg[`FBCR_MODE_HI:`FBCR_MODE_LO];
  assign plane_b_select = ctrl2_reg[`FBCR_PLANE_BIT];
  assign cpu_fence_enable = ctrl2_reg[`FBCR_FENCE_BIT];
  assign dbuf_disable = ctrl2_reg[`FBCR_DBUF_BIT];
  assign fence_display_y_offset = yoff_reg;
  assign mod_valid = modth_reg[0];

  // cpu writes count only when the buffer lies in a fence
  assign mod_event = buf_write || (cpu_fence_enable && cpu_fence_write);

  fbcr_modcnt u_modcnt (
    .mclk(mclk),
    .nrst(nrst),
    .mod_event(mod_event),
    .interval_end(interval_end),
    .threshold(modth_reg[31:1]),
    .count(mod_count),
    .reached(mod_reached)
  );

  // recompression only when interval count equals the programmed count or the valid bit is clear
  assign recompress_ok = !mod_valid ||
                         (interval_end && (mod_count == modth_reg[31:1]));
  // self refresh exit suppressed until enough modifications while the valid bit is set
  assign sr_exit_allow = !mod_valid || mod_reached;

  // idleness gating of self refresh entry
  assign idle_gates_sr = (idle_mode == `FBCR_IDLE_LOOK) ||
                         (idle_mode == `FBCR_IDLE_PAIR);

  // idle tracking; mode 10 forces idle at pair end or c3 entry
  always @* begin
    idle_next = !compressing;
    if (idle_mode == `FBCR_IDLE_PAIR) begin
      if (c3_entry_signal || (compressing && pair_done)) begin
        idle_next = 1'b1;
      end else if (idle_reg && compressing && !pair_done) begin
        idle_next = 1'b1;
      end
    end
  end
  assign compressor_idle = idle_reg;

  // two-bit tag field of a word; pair k sits at bits 2k+1:2k
  function [1:0] tag_field;
    input [31:0] word;
    input [3:0] pos;
    begin
      tag_field = word[{pos, 1'b1} -: 2];
    end
  endfunction

  // line to tag bit; an odd tile start pushes line 0 up to bit 1
  assign tag_bit = {1'b0, tag_line} + {11'h000, odd_tile_start};
  // 32 lines per word; the last word absorbs the odd start spill
  assign tag_idx = tag_bit[10:5];
  assign tag_pos = tag_bit[4:1];
  // bit 11 set means far beyond the table
  assign tag_in_range = !tag_bit[11] && (tag_idx <= `FBCR_TAG_LAST);

  // lines outside the table read as modified
  assign cur_tag = tag_in_range ?
                   tag_field(tag_reg[tag_idx], tag_pos) : `FBCR_TAG_MODIFIED;
  assign tag_rd_code = cur_tag;
  assign pair_modified = (cur_tag == `FBCR_TAG_MODIFIED);
  assign pair_eligible = (cur_tag == `FBCR_TAG_UNCOMP);
  assign pair_skip = (cur_tag == `FBCR_TAG_NOCOMP);
  assign pair_compressed = (cur_tag == `FBCR_TAG_COMP);

  assign host_idx = tag_index(reg_addr);
  assign host_tag_hit = tag_hit(reg_addr);

  // host write strobes, one per register
  assign ctrl2_wr = reg_wr && (reg_addr == `FBCR_CTRL2_ADDR);
  assign yoff_wr = reg_wr && (reg_addr == `FBCR_YOFF_ADDR);
  assign modth_wr = reg_wr && (reg_addr == `FBCR_MODTH_ADDR);
  assign host_tag_wr = reg_wr && host_tag_hit;
  // compressor updates beyond the table are dropped
  assign upd_tag_wr = tag_wr && tag_in_range;

  // compression control second; reserved bits kept at zero
  always @(posedge mclk) begin
    if (!nrst) begin
      ctrl2_reg <= `FBCR_RST_WORD;
    end else if (ctrl2_wr) begin
      ctrl2_reg <= reg_wdata & `FBCR_CTRL2_MASK;
    end
  end

  // display y offset, low 12 bits only
  always @(posedge mclk) begin
    if (!nrst) begin
      yoff_reg <= 12'h000;
    end else if (yoff_wr) begin
      yoff_reg <= reg_wdata[11:0];
    end
  end

  // modification threshold, valid flag in bit 0
  always @(posedge mclk) begin
    if (!nrst) begin
      modth_reg <= `FBCR_RST_WORD;
    end else if (modth_wr) begin
      modth_reg <= reg_wdata;
    end
  end

  // idle state; starts idle since no pass runs out of reset
  always @(posedge mclk) begin
    if (!nrst) begin
      idle_reg <= 1'b1;
    end else begin
      idle_reg <= idle_next;
    end
  end

  // tag storage; host write wins over compressor update of same word
  always @(posedge mclk) begin
    if (!nrst) begin
      for (i = 0; i < `FBCR_TAG_WORDS; i = i + 1) begin
        tag_reg[i] <= `FBCR_RST_WORD;
      end
    end else begin
      if (upd_tag_wr) begin
        tag_reg[tag_idx][{tag_pos, 1'b1} -: 2] <= tag_code;
      end
      if (host_tag_wr) begin
        tag_reg[host_idx] <= reg_wdata;
      end
    end
  end

  // read mux, registered; unmapped reads return zero
  always @* begin
    rdata_next = `FBCR_RST_WORD;
    case (reg_addr)
      `FBCR_CTRL2_ADDR: begin
        rdata_next = {compressing, ctrl2_reg[30:0]};
      end
      `FBCR_YOFF_ADDR: begin
        rdata_next = {20'h00000, yoff_reg};
      end
      `FBCR_MODTH_ADDR: begin
        rdata_next = modth_reg;
      end
      default: begin
        if (host_tag_hit) begin
          rdata_next = tag_reg[host_idx];
        end
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= `FBCR_RST_WORD;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// File: fbcr_defines.vh
`ifndef FBCR_DEFINES_VH
`define FBCR_DEFINES_VH
// register byte addresses
`define FBCR_ADDR_W 16
`define FBCR_CTRL2_ADDR 16'h3214
`define FBCR_YOFF_ADDR 16'h321B
`define FBCR_MODTH_ADDR 16'h3220
`define FBCR_TAG_BASE 16'h3300
`define FBCR_TAG_WORDS 49
`define FBCR_TAG_IDX_W 6
`define FBCR_TAG_LAST 6'h30
// compression control second fields
`define FBCR_PLANE_BIT 0
`define FBCR_FENCE_BIT 1
`define FBCR_MODE_LO 2
`define FBCR_MODE_HI 3
`define FBCR_DBUF_BIT 4
`define FBCR_CTRL2_MASK 32'h0000001F
`define FBCR_YOFF_MASK 32'h00000FFF
// low power idle mode codes
`define FBCR_IDLE_IGNORE 2'h0
`define FBCR_IDLE_LOOK 2'h1
`define FBCR_IDLE_PAIR 2'h2
// tag codes
`define FBCR_TAG_MODIFIED 2'h0
`define FBCR_TAG_UNCOMP 2'h1
`define FBCR_TAG_NOCOMP 2'h2
`define FBCR_TAG_COMP 2'h3
// reset values
`define FBCR_RST_WORD 32'h00000000
`endif

// File: fbcr_modcnt.v
`timescale 1ns/1ps
`default_nettype none
// counts display buffer modifications within an interval
module fbcr_modcnt (
  input wire mclk,
  input wire nrst,
  input wire mod_event,
  input wire interval_end,
  input wire [30:0] threshold,
  output wire [30:0] count,
  output wire reached
);
  reg [30:0] cnt_reg;
  reg [30:0] cnt_next;

  // count saturates; interval end restarts it
  always @* begin
    cnt_next = cnt_reg;
    if (interval_end) begin
      cnt_next = 31'h00000000;
    end else if (mod_event && (cnt_reg != 31'h7FFFFFFF)) begin
      cnt_next = cnt_reg + 31'h00000001;
    end
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      cnt_reg <= 31'h00000000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign count = cnt_reg;
  assign reached = (cnt_reg >= threshold);
endmodule
`default_nettype wire

// File: fbcr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbcr_defines.vh"
module fbcr_regs_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic compressing,
  input wire logic c3_entry_signal,
  input wire logic interval_end,
  input wire logic [1:0] tag_rd_code,
  input wire logic pair_skip,
  input wire logic pair_compressed,
  input wire logic plane_b_select,
  input wire logic cpu_fence_enable,
  input wire logic [11:0] fence_display_y_offset,
  input wire logic compressor_idle,
  input wire logic idle_gates_sr,
  input wire logic recompress_ok,
  input wire logic sr_exit_allow
);
  logic [31:0] c2;
  logic [31:0] yo;
  logic [31:0] mt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // shadow copies of host-written registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      c2 <= 32'h0;
      yo <= 32'h0;
      mt <= 32'h0;
    end else if (reg_wr) begin
      if (reg_addr == `FBCR_CTRL2_ADDR) c2 <= reg_wdata;
      if (reg_addr == `FBCR_YOFF_ADDR) yo <= reg_wdata;
      if (reg_addr == `FBCR_MODTH_ADDR) mt <= reg_wdata;
    end
  end
  plane_sel_a: assert property (plane_b_select == c2[0])
    else $error("plane select differs from written bit");
  fence_en_a: assert property (cpu_fence_enable == c2[1])
    else $error("fence enable differs from written bit");
  idle_gate_a: assert property (idle_gates_sr == (c2[3:2] == 2'h1 || c2[3:2] == 2'h2))
    else $error("idle gating wrong for mode");
  yoff_hold_a: assert property (fence_display_y_offset == yo[11:0])
    else $error("y offset differs from written value");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  busy_flag_a: assert property (reg_rd && reg_addr == `FBCR_CTRL2_ADDR |=>
    reg_rdata == {$past(compressing), 26'h0, $past(c2[4:0])})
    else $error("control readback wrong");
  c3_idle_a: assert property (c2[3:2] == 2'h2 && c3_entry_signal |=> compressor_idle)
    else $error("no idle after c3 entry");
  count_off_a: assert property (!mt[0] |-> recompress_ok && sr_exit_allow)
    else $error("count used while not valid");
  no_recomp_a: assert property (mt[0] && !interval_end |-> !recompress_ok)
    else $error("recompress outside interval end");
  tag_dec_a: assert property (pair_skip == (tag_rd_code == 2'h2) &&
    pair_compressed == (tag_rd_code == 2'h3))
    else $error("tag decode wrong");
  cover property (c2[3:2] == 2'h2 && c3_entry_signal);
  cover property (interval_end && recompress_ok && mt[0]);
  cover property (reg_rd && reg_addr == `FBCR_CTRL2_ADDR && compressing);
endmodule
bind fbcr_regs fbcr_regs_chk u_chk (.*);
`default_nettype wire

// File: fbcr_far.sv
`timescale 1ns/1ps
`default_nettype none
module fbcr_far (
  input wire logic mclk,
  output logic pair_done,
  output logic buf_write,
  output logic cpu_fence_write,
  output logic tag_wr,
  output logic [10:0] tag_line,
  output logic [1:0] tag_code
);
  // quiet far side at start
  initial begin
    {pair_done, buf_write, cpu_fence_write, tag_wr} = 4'h0;
    tag_line = 11'h0;
    tag_code = 2'h0;
  end
  // one modification pulse every two cycles, cpu or plane sourced
  task automatic mods(input int n, input logic cpu);
    repeat (n) begin
      @(negedge mclk);
      buf_write = !cpu;
      cpu_fence_write = cpu;
      @(negedge mclk);
      buf_write = 1'b0;
      cpu_fence_write = 1'b0;
    end
  endtask
  // compressor tag update; line stays as the lookup address
  task automatic tag(input logic [10:0] l, input logic [1:0] c);
    @(negedge mclk);
    tag_line = l;
    tag_code = c;
    tag_wr = 1'b1;
    @(negedge mclk);
    tag_wr = 1'b0;
    tag_code = ~c;
  endtask
endmodule
`default_nettype wire

// File: fbcr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbcr_defines.vh"
`define CK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module fbcr_regs_tb_top;
  logic mclk, nrst, reg_wr, reg_rd, compressing, c3_entry_signal, odd_tile_start, interval_end;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata;
  wire logic [31:0] reg_rdata;
  wire logic pair_done, buf_write, cpu_fence_write, tag_wr, pair_eligible, pair_skip;
  wire logic pair_compressed, pair_modified, plane_b_select, cpu_fence_enable, dbuf_disable;
  wire logic compressor_idle, idle_gates_sr, recompress_ok, sr_exit_allow;
  wire logic [10:0] tag_line;
  wire logic [1:0] tag_code, tag_rd_code;
  wire logic [11:0] fence_display_y_offset;
  int err_total = 0;
  int checks = 0;
  fbcr_regs u_dut (.*);
  fbcr_far u_far (.*);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic end_of_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    `CK(reg_rdata, e)
  endtask
  task automatic ivchk(input logic e);
    @(negedge mclk);
    interval_end = 1'b1;
    #1 `CK(recompress_ok, e)
    @(negedge mclk);
    interval_end = 1'b0;
  endtask
  // plane changes only while compressing is low
  task automatic t_ctrl;
    for (int m = 0; m < 3; m++) begin
      wr(`FBCR_CTRL2_ADDR, {27'h7FFFFFF, 1'b1, m[1:0], 2'h3});
      `CK(idle_gates_sr, m != 0)
      `CK({plane_b_select, cpu_fence_enable}, 2'h3)
      `CK(dbuf_disable, 1'b1)
      rd(`FBCR_CTRL2_ADDR, {27'h0, 1'b1, m[1:0], 2'h3});
    end
    wr(`FBCR_CTRL2_ADDR, 32'h0);
    `CK({plane_b_select, cpu_fence_enable, dbuf_disable}, 3'h0)
    wr(`FBCR_YOFF_ADDR, 32'hFFFFFFFF);
    rd(`FBCR_YOFF_ADDR, 32'h00000FFF);
  endtask
  task automatic t_mod;
    wr(`FBCR_MODTH_ADDR, 32'h7);
    u_far.mods(2, 1'b1);
    u_far.mods(2, 1'b0);
    `CK(sr_exit_allow, 1'b0)
    u_far.mods(1, 1'b0);
    `CK(sr_exit_allow, 1'b1)
    ivchk(1'b1);
    wr(`FBCR_CTRL2_ADDR, 32'h2);
    u_far.mods(4, 1'b1);
    ivchk(1'b0);
    wr(`FBCR_MODTH_ADDR, 32'h6);
    `CK({recompress_ok, sr_exit_allow}, 2'h3)
  endtask
  // 32 lines per tag word: line 64 lands in the third word
  task automatic t_tag;
    for (int c = 0; c < 4; c++) begin
      u_far.tag(11'd64, c[1:0]);
      `CK(tag_rd_code, c[1:0])
      `CK({pair_compressed, pair_skip, pair_eligible, pair_modified}, 4'h1 << c)
      rd(16'h3308, c);
    end
    odd_tile_start = 1'b1;
    u_far.tag(11'd63, 2'h2);
    u_far.tag(11'd0, 2'h1);
    odd_tile_start = 1'b0;
    u_far.tag(11'd70, 2'h3);
    rd(16'h3308, 32'h000000C2);
    rd(`FBCR_TAG_BASE, 32'h00000001);
    wr(16'h33C0, 32'hA5A5A5A5);
    rd(16'h33C0, 32'hA5A5A5A5);
    odd_tile_start = 1'b1;
    u_far.tag(11'd1535, 2'h3);
    odd_tile_start = 1'b0;
    rd(16'h33C0, 32'hA5A5A5A7);
    rd(16'h33C4, 32'h0);
  endtask
  task automatic t_idle;
    wr(`FBCR_CTRL2_ADDR, 32'h4);
    compressing = 1'b1;
    repeat (2) @(negedge mclk);
    `CK(compressor_idle, 1'b0)
    rd(`FBCR_CTRL2_ADDR, 32'h80000004);
    wr(`FBCR_CTRL2_ADDR, 32'h8);
    c3_entry_signal = 1'b1;
    @(negedge mclk);
    `CK(compressor_idle, 1'b1)
    {c3_entry_signal, compressing} = 2'h0;
  endtask
  // watchdog on the whole run
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_of_test;
  end
  initial begin
    {nrst, reg_wr, reg_rd, compressing, c3_entry_signal, odd_tile_start, interval_end} = 7'h0;
    reg_addr = 16'h0;
    reg_wdata = 32'h0;
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    rd(`FBCR_CTRL2_ADDR, 32'h0);
    rd(`FBCR_TAG_BASE, 32'h0);
    `CK(compressor_idle, 1'b1)
    t_ctrl;
    t_mod;
    t_tag;
    t_idle;
    end_of_test;
  end
endmodule
`default_nettype wire
